//--- core/level_duration_defines.svh
`ifndef LEVEL_DURATION_DEFINES_SVH
`define LEVEL_DURATION_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_PS        25000
// Count unit in picoseconds; 2 us variant, alternatives 800000 or 750000
`define UNIT_TIME_PS         2000000
`define UNIT_CYCLES          (`UNIT_TIME_PS / `CLK_PERIOD_PS)

// ----------------------------------------------------------------------
// Counter limits and results
// ----------------------------------------------------------------------
`define COUNT_MAX            16'hFFFF
`define RESULT_EARLY         16'h0001
`define RESULT_OVERFLOW      16'h0000
`define PIN_SEL_MAX          4'hF

`endif

//--- core/level_duration_measure.sv
// Behaviour
// - Pin selector 0 to 15 picks one of sixteen observed pins.
// - Starting switches selected pin to input, driver off, before counting.
// - Level bit names timed level; differing pin ends measurement, stores result.
// - Counter steps once per unit, stops at first unit pin mismatches.
// - Pin already differing at start gives result 1.
// - More than 65535 units at level ends with result 0.
// - Count unit fixed at design time from clock rate.
`timescale 1ns/100ps
`include "level_duration_defines.svh"

module level_duration_measure
    import level_duration_pkg::*;
(
    input  wire logic            i_clk_sys,
    input  wire logic            i_reset,
    input  wire logic            i_start,
    input  wire measure_req_type i_req,
    input  wire logic [15:0]     i_pin,
    input  wire logic [15:0]     i_drive_dir,
    output logic      [15:0]     o_pin_oe,
    output logic      [15:0]     o_result,
    output logic                 o_done,
    output logic                 o_busy
);

    localparam int UNIT_CYC = `UNIT_CYCLES;

    measure_state_type state_reg;
    measure_req_type   req_reg;
    logic [15:0]       pin_sync;
    logic [15:0]       count_reg;
    logic [15:0]       unit_div_reg;
    logic              unit_tick;
    logic              pin_match;

    // Pin sampling through the synchroniser
    pin_input_sync u_sync (
        .i_clk_sys    (i_clk_sys),
        .i_reset      (i_reset),
        .i_pin        (i_pin),
        .o_pin_stable (pin_sync)
    );

    // ------------------------------------------------------------------
    // Pin selection and level compare
    // ------------------------------------------------------------------
    // pin select mux
    assign pin_match = (pin_sync[req_reg.pin_sel] == req_reg.level);

    // ------------------------------------------------------------------
    // Unit divider
    // ------------------------------------------------------------------
    // fixed unit tick; restarts at start so first unit is full
    assign unit_tick = (unit_div_reg == 16'(UNIT_CYC - 1));

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            unit_div_reg <= 16'h0000;
        end else if (state_reg != ST_COUNT || unit_tick) begin
            unit_div_reg <= 16'h0000;
        end else begin
            unit_div_reg <= unit_div_reg + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // starts ignored unless idle
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= ST_IDLE;
            req_reg   <= '0;
            count_reg <= 16'h0000;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (i_start) begin
                        req_reg   <= i_req;
                        count_reg <= 16'h0000;
                        state_reg <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    // count one per unit, check at unit end
                    if (unit_tick) begin
                        count_reg <= count_reg + 16'h0001;
                        if (!pin_match || count_reg == `COUNT_MAX) begin
                            state_reg <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // selected pin driver released while busy
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_pin_oe <= 16'h0000;
        end else if (state_reg == ST_IDLE && i_start) begin
            o_pin_oe <= i_drive_dir & ~(16'h0001 << i_req.pin_sel);
        end else if (state_reg == ST_IDLE) begin
            o_pin_oe <= i_drive_dir;
        end else begin
            o_pin_oe <= i_drive_dir & ~(16'h0001 << req_reg.pin_sel);
        end
    end

    // early mismatch yields 1 because count steps 0 to 1
    // wrap at max gives 0 naturally
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_result <= 16'h0000;
            o_done   <= 1'b0;
            o_busy   <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (state_reg == ST_COUNT && unit_tick
                && (!pin_match || count_reg == `COUNT_MAX)) begin
                o_result <= count_reg + 16'h0001;
                o_done   <= 1'b1;
            end
            o_busy <= (state_reg == ST_IDLE) ? i_start
                    : (state_reg == ST_COUNT);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_done_pulse: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        o_done |=> !o_done)
        else $error("done longer than one clock");

    chk_result_stable: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        !o_done |=> (o_done || $stable(o_result)))
        else $error("result changed without done");

    chk_pin_released: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        (state_reg == ST_COUNT) |-> !o_pin_oe[req_reg.pin_sel])
        else $error("selected pin driven while counting");

    chk_busy_ignore: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        (state_reg == ST_COUNT && i_start) |=> $stable(req_reg))
        else $error("start accepted while busy");

    chk_unit_period: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        (state_reg == ST_COUNT && unit_tick) |=> !unit_tick[*8])
        else $error("unit tick too frequent");

    chk_early_one: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        (state_reg == ST_COUNT && unit_tick && count_reg == 16'h0000
         && !pin_match) |=> (o_done && o_result == `RESULT_EARLY))
        else $error("early mismatch not one");

    chk_overflow_zero: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        (state_reg == ST_COUNT && unit_tick && count_reg == `COUNT_MAX)
        |=> (o_done && o_result == `RESULT_OVERFLOW))
        else $error("overflow not zero");

    chk_stop_mismatch: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        (state_reg == ST_COUNT && unit_tick && !pin_match)
        |=> (state_reg == ST_DONE && o_result == $past(count_reg) + 16'h0001))
        else $error("count did not stop on mismatch");

    chk_level_continue: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        (state_reg == ST_COUNT && unit_tick && pin_match
         && count_reg != `COUNT_MAX) |=> state_reg == ST_COUNT)
        else $error("ended while pin at level");

    // An idle start must latch its request and raise busy at once
    chk_start_taken: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        (state_reg == ST_IDLE && i_start)
        |=> (state_reg == ST_COUNT && o_busy && req_reg == $past(i_req)))
        else $error("idle start not taken");

    // The done cycle refuses starts and always returns to idle
    chk_done_refuse: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        (state_reg == ST_DONE) |=> (state_reg == ST_IDLE && !o_busy))
        else $error("done state did not return to idle");

    // Between unit ends the count must not move
    chk_count_steady: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        (state_reg == ST_COUNT && !unit_tick) |=> $stable(count_reg))
        else $error("count moved inside a unit");

    chk_busy_count: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        (state_reg == ST_COUNT) |-> o_busy)
        else $error("busy low while counting");

    // Outside a measurement the caller owns every driver again
    chk_idle_follow: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        (state_reg == ST_IDLE && !i_start)
        |=> (o_pin_oe == $past(i_drive_dir)))
        else $error("idle drivers not following caller");

endmodule : level_duration_measure

//--- core/level_duration_pkg.sv
package level_duration_pkg;

    // Start request bundle
    typedef struct packed {
        logic [3:0] pin_sel;
        logic       level;
    } measure_req_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_COUNT = 3'b010,
        ST_DONE  = 3'b100
    } measure_state_type;

endpackage : level_duration_pkg

//--- core/pin_input_sync.sv
`timescale 1ns/100ps

// Three-stage synchroniser on all sixteen pins; a change is accepted
// only once stages two and three agree.
module pin_input_sync (
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset,
    input  wire logic [15:0] i_pin,
    output logic      [15:0] o_pin_stable
);

    logic [15:0] stage1_reg;
    logic [15:0] stage2_reg;
    logic [15:0] stage3_reg;

    // ------------------------------------------------------------------
    // Synchroniser chain
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            stage1_reg <= 16'h0000;
            stage2_reg <= 16'h0000;
            stage3_reg <= 16'h0000;
        end else begin
            stage1_reg <= i_pin;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // Agreement filter; holds last value while the stages differ
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_pin_stable <= 16'h0000;
        end else begin
            for (int i = 0; i < 16; i++) begin
                if (stage2_reg[i] == stage3_reg[i]) begin
                    o_pin_stable[i] <= stage3_reg[i];
                end
            end
        end
    end

endmodule : pin_input_sync

//--- tb/level_duration_measure_tb_top.sv
`timescale 1ns/100ps

module level_duration_measure_tb_top
    import level_duration_pkg::*;
;
    logic            clk_sys   = 1'b0;
    logic            reset     = 1'b1;
    logic            start     = 1'b0;
    measure_req_type req       = '0;
    logic [15:0]     drive_dir = 16'h0000;
    logic [15:0]     drive_val = 16'h0000;
    int              hold      = 1000;
    logic [15:0]     pin, pin_oe, result;
    logic            done, busy;
    logic [15:0]     prev      = 16'h0000;
    int              bad_count = 0;
    int              tests_run = 0;
    int              cyc       = 0;
    int              seed      = 32'hd1f7_cec5;
    logic [15:0]     exp_res_q [$];
    int              exp_cyc_q [$];

    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;

    level_duration_measure level_duration_measure_i (
        .i_clk_sys(clk_sys), .i_reset(reset), .i_start(start),
        .i_req(req), .i_pin(pin), .i_drive_dir(drive_dir),
        .o_pin_oe(pin_oe), .o_result(result), .o_done(done), .o_busy(busy));
    rc_network_model rc_network_model_i (
        .i_clk_sys(clk_sys), .i_pin_oe(pin_oe), .i_drive_val(drive_val),
        .i_hold(hold), .o_pin(pin));

    // ----------------------------------------
    // Checking and verdict
    // ----------------------------------------
    task check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : check

    task final_report();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    // Oldest note is compared whenever done appears
    always @(posedge clk_sys) begin
        #1;
        if (done === 1'b1) begin
            if (exp_res_q.size() == 0) begin
                check(1'b0, "unexpected done");
            end else begin
                check(result === exp_res_q.pop_front(), "result");
                check(cyc == exp_cyc_q.pop_front(), "done time");
            end
        end
    end

    // ----------------------------------------
    // One measurement, with a refused start
    // ----------------------------------------
    task run(input logic early, input int k);
        logic [3:0]  sel;
        logic        lvl;
        logic [15:0] e;
        int          n;
        sel = 4'($random(seed));
        lvl = 1'($random(seed));
        e = early ? 16'h0001 : 16'(k);
        @(posedge clk_sys);
        drive_dir <= 16'($random(seed)) | (16'h0001 << sel);
        drive_val <= (16'($random(seed)) & ~(16'h0001 << sel))
                     | (16'(lvl ^ early) << sel);
        hold <= early ? 1000 : k * 80 - 40; // Flip mid-unit, no race
        repeat (7) @(posedge clk_sys);
        #1;
        check(busy === 1'b0, "idle");
        @(posedge clk_sys);
        start <= 1'b1;
        req <= '{pin_sel: sel, level: lvl};
        @(posedge clk_sys);
        start <= 1'b0;
        #1;
        exp_res_q.push_back(e);
        // Done is launched by the edge that closes the last unit
        exp_cyc_q.push_back(cyc + (early ? 1 : k) * 80);
        @(posedge clk_sys);
        start <= 1'b1;
        req <= '{pin_sel: ~sel, level: ~lvl};
        @(posedge clk_sys);
        start <= 1'b0;
        #1;
        check(busy === 1'b1, "busy");
        check(result === prev, "result held");
        check(pin_oe === (drive_dir & ~(16'h0001 << sel)), "oe");
        prev = e;
        n = 0;
        while (done !== 1'b1 && n < 20000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check(n < 20000, "no done");
        $display("Test pin %0d level %0b units %0d ended", sel, lvl, e);
    endtask : run

    // Early mismatch, one unit, two units, then random lengths back to back
    // Early result one
    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        run(1'b1, 1);
        run(1'b0, 1);
        run(1'b0, 2);
        for (int i = 0; i < 6; i++)
            run(1'b0, 1 + $unsigned($random(seed)) % 40);
        final_report();
    end

    // Watchdog well beyond the longest expected run
    initial begin
        repeat (60000) @(posedge clk_sys);
        check(1'b0, "timeout");
        final_report();
    end
endmodule : level_duration_measure_tb_top

//--- tb/rc_network_model.sv
`timescale 1ns/100ps

// ----------------------------------------
// RC network on sixteen pins
// ----------------------------------------
module rc_network_model (
    input  wire logic        i_clk_sys,
    input  wire logic [15:0] i_pin_oe,
    input  wire logic [15:0] i_drive_val,
    input  wire logic [31:0] i_hold,
    output logic      [15:0] o_pin
);
    int          cnt [16];
    logic [15:0] last = 16'h0000;

    // Driven pins charge at once; released pins decay after i_hold cycles
    // Holds preconditioned level
    always @(posedge i_clk_sys) begin
        for (int p = 0; p < 16; p++) begin
            if (i_pin_oe[p]) begin
                o_pin[p] <= i_drive_val[p];
                last[p]  <= i_drive_val[p];
                cnt[p]   <= 0;
            end else if (cnt[p] < i_hold) begin
                cnt[p] <= cnt[p] + 1;
            end else begin
                o_pin[p] <= ~last[p]; // Cap has crossed the threshold
            end
        end
    end
endmodule : rc_network_model
